// [design/isolation_pkg.sv]
/*
  Constants and carrier types for the pin-isolation test mode control.
  Assumes a single ref_clk domain at 25 MHz; strap and reset pins are asynchronous.
*/
// Summary of operation
// - isolation mode floats all outputs and bidirectionals except the oscillator pad
// - oscillator output keeps driving during isolation
// - strap low during reset enters isolation
// - stays active while strap and reset low
// - strap high during reset exits isolation
// - reset release with strap low latches mode
// - latched mode ignores strap level while reset is high
// - reset reassertion without strap low exits latch
package isolation_pkg;

  localparam int CLK_PERIOD_NS  = 40;
  localparam int HOLD_CLOCKS    = 1;
  localparam int SYNC_STAGES    = 2;
  localparam int PIN_COUNT      = 8;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_HELD,
    MODE_LATCHED
  } mode_t;

  typedef struct packed {
    logic strap_n;
    logic reset_n;
  } pins_t;

endpackage

// [design/pin_sync.sv]
/*
  Two-stage level synchroniser for a bundle of asynchronous pins.
  Assumes a free-running clock and a synchronous-release reset.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int                 WIDTH = 2,
  parameter logic [WIDTH-1:0]   INIT  = '1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // pins idle high so reset shows no request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      dout <= INIT;
    end else if (ce) begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // pin_sync

// [design/pin_isolation_test_mode.sv]
/*
  Pin-isolation test mode control: decides when every driven pin except the oscillator pad floats.
  Assumes the chip's pad ring uses pin_oe_n (low = drive) per pin.
*/
`timescale 1ns/1ns
module pin_isolation_test_mode #(
  parameter int PINS = isolation_pkg::PIN_COUNT
) (
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  input  wire logic            clk_en,
  input  wire logic            test_isolate_strap,
  input  wire logic            reset_input_n,
  input  wire logic [PINS-1:0] core_oe_n,
  input  wire logic            osc_drive,
  output logic      [PINS-1:0] pin_oe_n,
  output logic                 oscillator_output,
  output logic                 oscillator_output_oe_n,
  output logic                 pin_isolation_mode,
  output logic                 mode_latched
);

  //////////////////////////////////////////////////////////////////////
  // decode helpers

  // one decode serves the pads and the pin_isolation_mode flag
  function automatic logic is_isolating(
    input isolation_pkg::mode_t mode
  );
    is_isolating = (mode != isolation_pkg::MODE_NORMAL);
  endfunction

  function automatic logic is_latched(
    input isolation_pkg::mode_t mode
  );
    is_latched = (mode == isolation_pkg::MODE_LATCHED);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // reset release

  // asserts at once with rstn, leaves through two flops: no runt release edge
  // every other flop in this block resets from rst_n_int
  logic [1:0] rst_pipe;
  logic       rst_n_int;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end

  assign rst_n_int = rst_pipe[1];

  //////////////////////////////////////////////////////////////////////
  // pin sampling

  isolation_pkg::pins_t raw;
  isolation_pkg::pins_t sync;

  assign raw = isolation_pkg::pins_t'{strap_n: test_isolate_strap, reset_n: reset_input_n};

  // one synchroniser for both pins keeps their relative timing
  // sampled on edges
  pin_sync #(
    .WIDTH ($bits(isolation_pkg::pins_t)),
    .INIT  ('1)
  ) u_sync (
    .clk   (ref_clk),
    .rst_n (rst_n_int),
    .ce    (clk_en),
    .din   (raw),
    .dout  (sync)
  );

  //////////////////////////////////////////////////////////////////////
  // pin decode

  logic strap_low;
  logic reset_low;
  logic enter_cond;
  logic latch_cond;
  logic leave_cond;
  logic exit_cond;

  assign strap_low  = !sync.strap_n;
  assign reset_low  = !sync.reset_n;
  assign enter_cond = reset_low && strap_low;
  assign latch_cond = !reset_low && strap_low;
  assign leave_cond = !strap_low;
  assign exit_cond  = reset_low && !strap_low;

  //////////////////////////////////////////////////////////////////////
  // mode state machine

  isolation_pkg::mode_t state;
  isolation_pkg::mode_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      isolation_pkg::MODE_NORMAL: begin
        if (enter_cond) begin
          next_state = isolation_pkg::MODE_HELD;
        end else begin
          next_state = isolation_pkg::MODE_NORMAL;
        end
      end
      isolation_pkg::MODE_HELD: begin
        if (leave_cond) begin
          next_state = isolation_pkg::MODE_NORMAL;
        end else if (latch_cond) begin
          next_state = isolation_pkg::MODE_LATCHED;
        end else begin
          next_state = isolation_pkg::MODE_HELD;
        end
      end
      isolation_pkg::MODE_LATCHED: begin
        if (enter_cond) begin
          next_state = isolation_pkg::MODE_HELD;
        end else if (exit_cond) begin
          next_state = isolation_pkg::MODE_NORMAL;
        end else begin
          next_state = isolation_pkg::MODE_LATCHED;
        end
      end
      default: begin
        next_state = isolation_pkg::MODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state <= isolation_pkg::MODE_NORMAL;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pad enables

  // pads switch on the same edge as state, not a clock behind it
  logic            isolate_next;
  logic            latched_next;
  logic [PINS-1:0] next_pin_oe_n;

  assign isolate_next = is_isolating(next_state);
  assign latched_next = is_latched(next_state);

  // per-pin select keeps each pad path separate in timing reports
  // float all pins
  for (genvar i = 0; i < PINS; i++) begin : g_pad
    assign next_pin_oe_n[i] = isolate_next ? 1'h1 : core_oe_n[i];
  end

  // oe_n high floats the pad
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pin_oe_n <= '1;
    end else if (clk_en) begin
      pin_oe_n <= next_pin_oe_n;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // oscillator pad

  // never floated: a crystal on this pin would stop oscillating
  // registered like every other pad so its timing matches
  // oscillator keeps driving
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      oscillator_output      <= 1'h0;
      oscillator_output_oe_n <= 1'h0;
    end else if (clk_en) begin
      oscillator_output      <= osc_drive;
      oscillator_output_oe_n <= 1'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status flags

  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pin_isolation_mode <= 1'h0;
    end else if (clk_en) begin
      pin_isolation_mode <= isolate_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      mode_latched <= 1'h0;
    end else if (clk_en) begin
      mode_latched <= latched_next;
    end
  end

  // a pin that moves near a clock edge can land one clock after the
  // other, so strap should stay low a few clocks past reset release
  // rather than the bare minimum of one

endmodule // pin_isolation_test_mode

// [testbench/iso_chk.sv]
/* checker for the pin isolation control
   sees the top ports only; bound at the foot */
`timescale 1ns/1ns
module iso_chk #(parameter int PINS = 8) (
  input wire logic            ref_clk,
  input wire logic            rstn,
  input wire logic            clk_en,
  input wire logic            test_isolate_strap,
  input wire logic            reset_input_n,
  input wire logic [PINS-1:0] core_oe_n,
  input wire logic            osc_drive,
  input wire logic [PINS-1:0] pin_oe_n,
  input wire logic            oscillator_output,
  input wire logic            oscillator_output_oe_n,
  input wire logic            pin_isolation_mode,
  input wire logic            mode_latched
);
  wire s = test_isolate_strap;
  wire r = reset_input_n;
  wire e = clk_en;
  // internal reset leaves two edges after rstn; outputs settle later
  logic [2:0] up_cnt;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) up_cnt <= 3'h0;
    else if (up_cnt != 3'h4) up_cnt <= up_cnt + 3'h1;
  end
  wire live = rstn && (up_cnt == 3'h4);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!live);
  ////////////////////////////////////////
  sequence s_held; pin_isolation_mode && !s && !r && e; endsequence
  property p_float; pin_isolation_mode |-> &pin_oe_n; endproperty
  a_float: assert property (p_float) else $error("pin driven in isolation");
  property p_osc; !oscillator_output_oe_n; endproperty
  a_osc: assert property (p_osc) else $error("oscillator floated");
  property p_osc_val; $past(e) |-> oscillator_output == $past(osc_drive); endproperty
  a_osc_val: assert property (p_osc_val) else $error("oscillator value wrong");
  property p_enter; (!s && !r && e) [*4] |-> pin_isolation_mode; endproperty
  a_enter: assert property (p_enter) else $error("no entry");
  property p_hold; s_held [*3] |=> pin_isolation_mode; endproperty
  a_hold: assert property (p_hold) else $error("mode dropped");
  property p_leave; (s && !r && e) [*4] |-> !pin_isolation_mode; endproperty
  a_leave: assert property (p_leave) else $error("no exit");
  property p_latch; s_held ##1 (r && !s && e) [*4] |-> mode_latched; endproperty
  a_latch: assert property (p_latch) else $error("not latched");
  property p_keep; (mode_latched && r) [*3] |=> mode_latched; endproperty
  a_keep: assert property (p_keep) else $error("latch lost");
  property p_path;
    !pin_isolation_mode && $past(e) |-> pin_oe_n == $past(core_oe_n);
  endproperty
  a_path: assert property (p_path) else $error("enable path wrong");
endmodule // iso_chk
bind pin_isolation_test_mode iso_chk #(.PINS(PINS)) i_iso_chk (
  .ref_clk                (ref_clk),
  .rstn                   (rstn),
  .clk_en                 (clk_en),
  .test_isolate_strap     (test_isolate_strap),
  .reset_input_n          (reset_input_n),
  .core_oe_n              (core_oe_n),
  .osc_drive              (osc_drive),
  .pin_oe_n               (pin_oe_n),
  .oscillator_output      (oscillator_output),
  .oscillator_output_oe_n (oscillator_output_oe_n),
  .pin_isolation_mode     (pin_isolation_mode),
  .mode_latched           (mode_latched)
);

// [testbench/pin_tester.sv]
/* board tester model driving strap and reset pins
   assumes callers change levels at falling edges */
`timescale 1ns/1ns
module pin_tester (
  output logic strap,
  output logic rin
);
  initial {strap, rin} = 2'b11;
  task automatic put(input logic st, input logic rs);
    {strap, rin} = {st, rs};
  endtask
endmodule // pin_tester

// [testbench/pin_isolation_test_mode_bench.sv]
/* bench for the pin isolation control
   assumes 25 MHz clock, pins settle within 3 clocks */
`timescale 1ns/1ns
module pin_isolation_test_mode_bench;
  logic       ref_clk = 0, rstn = 0, osc = 0, ce = 1;
  logic       strap, rin, iso, lat, osc_oe_n, osc_out;
  logic [7:0] pin_oe_n, core_oe_n = 8'hFF;
  int         error_cnt = 0, comparisons = 0;
  always #20 ref_clk = ~ref_clk;
  pin_tester i_pin_tester (.strap(strap), .rin(rin));
  pin_isolation_test_mode i_pin_isolation_test_mode (.ref_clk(ref_clk), .rstn(rstn),
    .clk_en(ce), .test_isolate_strap(strap), .reset_input_n(rin), .core_oe_n(core_oe_n),
    .osc_drive(osc), .pin_oe_n(pin_oe_n), .oscillator_output(osc_out),
    .oscillator_output_oe_n(osc_oe_n), .pin_isolation_mode(iso), .mode_latched(lat));
  ////////////////////////////////////////
  task chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_osc(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pad follows the oscillator one clock later
  task osc_follow;
    osc = 1'h1;
    @(negedge ref_clk);
    chk_osc({osc_oe_n, osc_out}, 2'h1);
    osc = 1'h0;
    @(negedge ref_clk);
    chk_osc({osc_oe_n, osc_out}, 2'h0);
  endtask
  // one extra clock beyond sync latency
  task step(input logic st, input logic rs, input logic [9:0] exp);
    i_pin_tester.put(st, rs);
    repeat (4) @(negedge ref_clk);
    chk({iso, lat, pin_oe_n}, exp);
  endtask
  task t_enter;
    step(0, 1, 10'h05A);
    step(0, 0, 10'h2FF);
    step(0, 0, 10'h2FF);
    chk({9'h000, osc_oe_n}, 10'h000);
    osc_follow;
    step(1, 0, 10'h05A);
    $display("enter and leave done");
  endtask
  task t_latch;
    step(0, 0, 10'h2FF);
    step(0, 1, 10'h3FF);
    step(1, 1, 10'h3FF);
    step(0, 1, 10'h3FF);
    step(1, 0, 10'h05A);
    step(0, 0, 10'h2FF);
    step(0, 1, 10'h3FF);
    step(0, 0, 10'h2FF);
    step(1, 0, 10'h05A);
    $display("latch done");
  endtask
  task t_freeze;
    ce = 1'h0;
    osc = 1'h1;
    step(0, 0, 10'h05A);
    chk_osc({osc_oe_n, osc_out}, 2'h0);
    ce = 1'h1;
    repeat (4) @(negedge ref_clk);
    chk({iso, lat, pin_oe_n}, 10'h2FF);
    chk_osc({osc_oe_n, osc_out}, 2'h1);
    osc = 1'h0;
    step(1, 0, 10'h05A);
    $display("clock enable freeze done");
  endtask
  task t_reset;
    step(0, 0, 10'h2FF);
    step(0, 1, 10'h3FF);
    i_pin_tester.put(1, 1);
    rstn = 0;
    @(negedge ref_clk);
    chk({iso, lat, pin_oe_n}, 10'h0FF);
    chk_osc({osc_oe_n, osc_out}, 2'h0);
    rstn = 1;
    repeat (4) @(negedge ref_clk);
    chk({iso, lat, pin_oe_n}, 10'h05A);
    $display("mid-run reset done");
  endtask
  task give_verdict;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    rstn = 1;
    repeat (3) @(negedge ref_clk);
    core_oe_n = 8'h5A;
    t_enter;
    t_latch;
    t_freeze;
    t_reset;
    give_verdict;
  end
endmodule // pin_isolation_test_mode_bench
